/* File: dwd_pkg.sv */
/*
 * constants for the dual wiper serial command decoder: frame layout,
 * opcodes, wiper and slot widths, reset values and busy timing.
 * assumes a single 125 MHz system clock.
 */
package dwd_pkg;
  // frame layout, msb first
  localparam int CMD_BITS = 24;
  localparam int CNT_W = 5;
  localparam int OPC_MSB = 23;
  localparam int OPC_LSB = 20;
  localparam int SLOT_MSB = 19;
  localparam int SLOT_LSB = 18;
  localparam int CHAN_HI = 17;
  localparam int CHAN_LO = 16;
  localparam int BMODE_POS = 8;
  localparam int DATA_MSB = 7;
  localparam int WIPER_W = 8;
  localparam int SLOT_W = 9;
  localparam int NUM_CHAN = 2;
  localparam int NUM_SLOT = 4;
  localparam int RDPAD_W = CMD_BITS - SLOT_W;

  // opcode_field codes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_WAKE = 4'h1;
  localparam logic [3:0] OP_PROG = 4'h2;
  localparam logic [3:0] OP_SAVE = 4'h3;
  localparam logic [3:0] OP_WRITE = 4'h4;
  localparam logic [3:0] OP_UP = 4'h7;
  localparam logic [3:0] OP_SLEEP = 4'h8;
  localparam logic [3:0] OP_SRST = 4'h9;
  localparam logic [3:0] OP_RDSLOT = 4'ha;
  localparam logic [3:0] OP_LOAD = 4'hb;
  localparam logic [3:0] OP_RDWIPER = 4'hc;
  localparam logic [3:0] OP_ERASE = 4'hd;
  localparam logic [3:0] OP_DOWN = 4'hf;

  // saved slot values and wiper limits
  localparam logic [SLOT_W-1:0] SLOT_ERASED = 9'h1ff;
  localparam logic [SLOT_W-1:0] SLOT_INIT = 9'h080;
  localparam logic [WIPER_W-1:0] WIPER_MAX = 8'hff;
  localparam logic [WIPER_W-1:0] WIPER_MIN = 8'h00;

  // busy time for slot access and wiper read
  localparam int CLK_NS = 8;
  localparam int BUSY_NS = 2000000;
  localparam int BUSY_W = 18;
endpackage

/* File: dwd_decoder.sv */
/*
 * serial command decoder for a two channel digital potentiometer:
 * frame capture, command execution, saved slots and ready/busy.
 * assumes link pins arrive asynchronously and are far slower than mclk.
 */
`timescale 1ns/100ps
module dwd_decoder
  import dwd_pkg::*;
#(
  parameter int unsigned BUSY_CYCLES = BUSY_NS / CLK_NS
) (
  // system
  input wire logic mclk,
  input wire logic sys_rst,
  // serial link pins
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic ready_busy,
  // protection strap
  input wire logic wp_n,
  // channel outputs
  output logic [WIPER_W-1:0] wiper_ch0,
  output logic [WIPER_W-1:0] wiper_ch1,
  output logic buffer_on_ch0,
  output logic buffer_on_ch1,
  output logic asleep
);
  // synchronisers, third stage for edges
  logic clk_s1, clk_s2, clk_s3, cs_s1, cs_s2, cs_s3, sdi_s1, sdi_s2;
  logic wp_s1, wp_s2;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      clk_s1 <= link_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      sdi_s1 <= sdi;
      sdi_s2 <= sdi_s1;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
    end
  end

  logic clk_rise, clk_fall, cs_fall, cs_rise, selected;
  assign clk_rise = clk_s2 & ~clk_s3;
  assign clk_fall = ~clk_s2 & clk_s3;
  assign cs_fall = ~cs_s2 & cs_s3;
  assign cs_rise = cs_s2 & ~cs_s3;
  assign selected = ~cs_s2;

  // main state
  logic [CMD_BITS-1:0] in_sr, next_in_sr, out_sr, next_out_sr;
  logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
  logic [BUSY_W-1:0] busy_cnt, next_busy_cnt;
  logic [WIPER_W-1:0] wiper [NUM_CHAN];
  logic [WIPER_W-1:0] next_wiper [NUM_CHAN];
  logic bmode [NUM_CHAN];
  logic next_bmode [NUM_CHAN];
  logic [SLOT_W-1:0] slot [NUM_CHAN][NUM_SLOT];
  logic [SLOT_W-1:0] next_slot [NUM_CHAN][NUM_SLOT];
  logic next_sdo, next_sdo_oe, next_ready, next_asleep;

  // decoded frame fields
  logic exec, chan_ok, busy_op;
  logic [3:0] opc;
  logic ch;
  logic [1:0] sl;
  assign opc = in_sr[OPC_MSB:OPC_LSB];
  assign ch = in_sr[CHAN_LO];
  assign sl = in_sr[SLOT_MSB:SLOT_LSB];
  assign chan_ok = ~in_sr[CHAN_HI];
  assign exec = cs_rise && bit_cnt == CNT_W'(CMD_BITS) &&
                busy_cnt == '0;
  assign busy_op = opc == OP_RDWIPER || opc == OP_RDSLOT ||
                   opc == OP_PROG || opc == OP_LOAD || opc == OP_SAVE;

  always_comb begin
    next_in_sr = in_sr;
    next_out_sr = out_sr;
    next_bit_cnt = bit_cnt;
    next_busy_cnt = busy_cnt;
    next_sdo = sdo;
    next_sdo_oe = sdo_oe;
    next_asleep = asleep;
    next_wiper = wiper;
    next_bmode = bmode;
    next_slot = slot;
    if (busy_cnt != '0) begin
      next_busy_cnt = busy_cnt - 1'b1;
    end
    if (cs_fall) begin
      next_bit_cnt = '0;
      next_sdo = out_sr[CMD_BITS-1];
      next_sdo_oe = 1'b1;
    end
    if (selected && clk_rise) begin
      next_in_sr = {in_sr[CMD_BITS-2:0], sdi_s2};
      if (bit_cnt != '1) begin
        next_bit_cnt = bit_cnt + 1'b1;
      end
    end
    if (selected && clk_fall) begin
      next_out_sr = {out_sr[CMD_BITS-2:0], 1'b0};
      next_sdo = out_sr[CMD_BITS-2];
    end
    if (cs_rise) begin
      next_sdo_oe = 1'b0;
    end
    // frames of any other length are dropped
    if (exec) begin
      next_out_sr = in_sr;
      if (asleep) begin
        if (opc == OP_WAKE) begin
          next_asleep = 1'b0;
        end
      end else begin
        if (busy_op) begin
          next_busy_cnt = BUSY_W'(BUSY_CYCLES);
        end
        unique case (opc)
          OP_RDWIPER: if (chan_ok) begin
            next_out_sr = {RDPAD_W'(0), bmode[ch], wiper[ch]};
          end
          OP_WRITE: if (chan_ok) begin
            next_wiper[ch] = in_sr[DATA_MSB:0];
          end
          OP_RDSLOT: if (chan_ok) begin
            next_out_sr = {RDPAD_W'(0), slot[ch][sl]};
          end
          // programming only clears bits, so an erase must come first
          OP_PROG: if (chan_ok && wp_s2) begin
            next_slot[ch][sl] = slot[ch][sl] &
                                in_sr[BMODE_POS:0];
          end
          OP_LOAD: if (chan_ok) begin
            {next_bmode[ch], next_wiper[ch]} = slot[ch][sl];
          end
          OP_SAVE: if (chan_ok && wp_s2) begin
            next_slot[ch][sl] = slot[ch][sl] &
                                {bmode[ch], wiper[ch]};
          end
          OP_UP: if (chan_ok && wiper[ch] != WIPER_MAX) begin
            next_wiper[ch] = wiper[ch] + 1'b1;
          end
          OP_DOWN: if (chan_ok && wiper[ch] != WIPER_MIN) begin
            next_wiper[ch] = wiper[ch] - 1'b1;
          end
          OP_SLEEP: next_asleep = 1'b1;
          OP_ERASE: if (chan_ok && wp_s2) begin
            next_slot[ch][sl] = SLOT_ERASED;
          end
          OP_SRST: begin
            next_asleep = 1'b1;
            for (int c = 0; c < NUM_CHAN; c++) begin
              {next_bmode[c], next_wiper[c]} = slot[c][0];
            end
          end
          default: ;
        endcase
      end
    end
    next_ready = next_busy_cnt == '0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      in_sr <= '0;
      out_sr <= '0;
      bit_cnt <= '0;
      busy_cnt <= '0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      ready_busy <= 1'b1;
      asleep <= 1'b1;
      for (int c = 0; c < NUM_CHAN; c++) begin
        {bmode[c], wiper[c]} <= SLOT_INIT;
        for (int s = 0; s < NUM_SLOT; s++) begin
          slot[c][s] <= SLOT_INIT;
        end
      end
    end else begin
      in_sr <= next_in_sr;
      out_sr <= next_out_sr;
      bit_cnt <= next_bit_cnt;
      busy_cnt <= next_busy_cnt;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      ready_busy <= next_ready;
      asleep <= next_asleep;
      wiper <= next_wiper;
      bmode <= next_bmode;
      slot <= next_slot;
    end
  end

  // buffer mode 1 means buffer on
  assign wiper_ch0 = wiper[0];
  assign wiper_ch1 = wiper[1];
  assign buffer_on_ch0 = bmode[0];
  assign buffer_on_ch1 = bmode[1];

  logic awake_exec;
  assign awake_exec = exec && !asleep;

  AST_NOP_HOLDS: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && opc == OP_NOP |=> $stable(wiper[0]) &&
    $stable(wiper[1]) && $stable(asleep) && $stable(slot[0][0]))
    else $error("nop changed state");
  AST_WRITE_WIPER: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && opc == OP_WRITE && chan_ok && !ch |=>
    wiper[0] == $past(in_sr[DATA_MSB:0]))
    else $error("wiper write lost");
  AST_UP_SAT: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && opc == OP_UP && chan_ok && !ch |=>
    wiper[0] == (($past(wiper[0]) == WIPER_MAX) ? WIPER_MAX :
    $past(wiper[0]) + 8'h01))
    else $error("up step wrong");
  AST_DOWN_SAT: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && opc == OP_DOWN && chan_ok && ch |=>
    wiper[1] == (($past(wiper[1]) == WIPER_MIN) ? WIPER_MIN :
    $past(wiper[1]) - 8'h01))
    else $error("down step wrong");
  AST_SLEEP_IGNORES: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && asleep && opc != OP_WAKE |=> asleep && $stable(wiper[0]) &&
    $stable(wiper[1]) && $stable(slot[1][3]))
    else $error("command acted in sleep");
  AST_BUSY_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && busy_op |=> !ready_busy)
    else $error("ready not dropped");
  AST_WP_BLOCKS: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && !wp_s2 && !ch && sl == 2'h0 |=> $stable(slot[0][0]))
    else $error("slot changed under protect");
  AST_BMODE_KEPT: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && (opc == OP_WRITE || opc == OP_UP || opc == OP_DOWN) |=>
    $stable(bmode[0]) && $stable(bmode[1]))
    else $error("buffer mode changed");
  AST_HIGH_CHAN: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && !chan_ok |=> $stable(wiper[0]) && $stable(wiper[1]))
    else $error("unused channel acted");
  AST_SDO_DRIVE: assert property (@(posedge mclk) disable iff (sys_rst)
    cs_fall |=> sdo_oe && sdo == $past(out_sr[CMD_BITS-1]))
    else $error("sdo not presented at select");
  AST_WAKE_ONLY: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && asleep && opc == OP_WAKE |=> !asleep)
    else $error("wake did not leave sleep");
  AST_SRST_RELOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && opc == OP_SRST |=> asleep &&
    {bmode[0], wiper[0]} == $past(slot[0][0]) &&
    {bmode[1], wiper[1]} == $past(slot[1][0]))
    else $error("soft reset did not restore power-up state");
  AST_ERASE_SLOT: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && opc == OP_ERASE && wp_s2 && chan_ok && !ch &&
    sl == 2'h0 |=> slot[0][0] == SLOT_ERASED)
    else $error("slot not erased");
  AST_LOAD_SLOT: assert property (@(posedge mclk) disable iff (sys_rst)
    awake_exec && opc == OP_LOAD && chan_ok && ch && sl == 2'h1 |=>
    {bmode[1], wiper[1]} == $past(slot[1][1]))
    else $error("slot load lost");
endmodule

/* File: dwd_host_model.sv */
/* host side of the serial link: frames commands, collects sdo.
   assumes all pins move on rising mclk edges. */
`timescale 1ns/100ps
module dwd_host_model (
  // system
  input wire logic mclk,
  // link pins
  output logic link_clk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic ready_busy,
  // frame result
  output logic done,
  output logic busy_seen,
  output logic [23:0] rx
);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    done = 1'b0;
    busy_seen = 1'b0;
    rx = 24'h0;
  end
  task automatic wait_ready();
    for (int w = 0; w < 300 && ready_busy !== 1'b1; w++)
      @(posedge mclk);
  endtask
  task automatic frame(input logic [23:0] c, input int nbits);
    wait_ready();
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int i = 0; i < nbits; i++) begin
      sdi <= c[23-i];
      repeat (8) @(posedge mclk);
      link_clk <= 1'b1;
      repeat (8) @(posedge mclk);
      rx <= {rx[22:0], sdo};
      link_clk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    busy_seen <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk);
      if (ready_busy === 1'b0) busy_seen <= 1'b1;
    end
    wait_ready();
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    repeat (76) @(posedge mclk);
  endtask
endmodule

/* File: dwd_decoder_bench.sv */
/* bench for dwd_decoder: reference model, note queue, scoreboard.
   assumes a short busy count and the host model on the link. */
`timescale 1ns/100ps
module dwd_decoder_bench;
  import dwd_pkg::*;
  typedef struct packed {
    logic [23:0] word;
    logic chk;
    logic [1:0] bsy;
    logic [18:0] st;
  } dwd_note_type;
  logic mclk, sys_rst, wp_n, link_clk, cs_n, sdi, sdo, ready_busy, asleep;
  logic [7:0] wiper_ch0, wiper_ch1;
  logic buffer_on_ch0, buffer_on_ch1, done, busy_seen, sdo_oe, oe_hi;
  logic [23:0] rx, m_out;
  logic [18:0] seen;
  logic [7:0] m_w[2];
  logic m_b[2], m_slp, m_ok;
  logic [8:0] m_s[2][4];
  logic [31:0] seed;
  logic [3:0] ops[5] = '{OP_WRITE, OP_UP, OP_DOWN, OP_NOP, OP_RDWIPER};
  int err_count, n_tests;
  dwd_note_type notes[$];
  logic [25:0] seq[34] = '{
    26'h0000000, 26'h04000a5,
    26'h0100000, 26'h04000ff, 26'h0700000,
    26'h0410001, 26'h0f10000, 26'h0f10000,
    26'h0420033, 26'h0c00000, 26'h0000000,
    26'h0d50000, 26'h0a50000, 26'h025013c,
    26'h0b50000, 26'h0410077, 26'h0d90000,
    26'h0390000, 26'h0a90000, 26'h0000000,
    26'h2d00000, 26'h2a00000, 26'h2b00000, 26'h2000000,
    26'h14000aa, 26'h0000000,
    26'h0800000, 26'h0700000, 26'h0900000, 26'h0100000,
    26'h0d00000, 26'h020015a, 26'h0900000, 26'h0100000
  };
  assign seen = {asleep, buffer_on_ch1, buffer_on_ch0, wiper_ch1, wiper_ch0};
  dwd_decoder #(.BUSY_CYCLES(20)) dwd_decoder_i (.mclk(mclk),
    .sys_rst(sys_rst), .link_clk(link_clk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .ready_busy(ready_busy), .wp_n(wp_n),
    .wiper_ch0(wiper_ch0), .wiper_ch1(wiper_ch1),
    .buffer_on_ch0(buffer_on_ch0), .buffer_on_ch1(buffer_on_ch1),
    .asleep(asleep));
  dwd_host_model dwd_host_model_i (.mclk(mclk), .link_clk(link_clk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .ready_busy(ready_busy),
    .done(done), .busy_seen(busy_seen), .rx(rx));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input string what, input logic [23:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic power_up();
    for (int k = 0; k < 2; k++) {m_b[k], m_w[k]} = m_s[k][0];
    m_slp = 1'b1;
  endtask
  task automatic send(input logic [23:0] c, input int nb = 24);
    dwd_note_type n;
    logic [8:0] rd;
    logic [3:0] op;
    logic h, act, rdop;
    op = c[23:20];
    h = c[16];
    act = nb == 24 && (!m_slp || op == OP_WAKE);
    rdop = 1'b0;
    n.word = m_out;
    n.chk = m_ok && nb == 24;
    n.bsy = 2'b00;
    if (act && op == OP_WAKE) m_slp = 1'b0;
    if (act && op == OP_SLEEP) m_slp = 1'b1;
    if (act && op == OP_SRST) power_up();
    if (act && !c[17]) begin
      n.bsy = 2'b10;
      case (op)
        OP_WRITE: m_w[h] = c[7:0];
        OP_UP: if (m_w[h] != WIPER_MAX) m_w[h]++;
        OP_DOWN: if (m_w[h] != WIPER_MIN) m_w[h]--;
        OP_ERASE: if (wp_n) m_s[h][c[19:18]] = SLOT_ERASED;
        OP_PROG: if (wp_n) m_s[h][c[19:18]] &= c[8:0];
        OP_SAVE: if (wp_n) m_s[h][c[19:18]] &= {m_b[h], m_w[h]};
        OP_LOAD: {m_b[h], m_w[h]} = m_s[h][c[19:18]];
        OP_RDWIPER: rd = {m_b[h], m_w[h]};
        OP_RDSLOT: rd = m_s[h][c[19:18]];
        default: n.bsy = 2'b00;
      endcase
      if (op inside {OP_RDWIPER, OP_RDSLOT, OP_LOAD, OP_PROG, OP_SAVE})
        n.bsy = (c[23] || wp_n) ? 2'b11 : 2'b00;
      rdop = op inside {OP_RDWIPER, OP_RDSLOT};
    end
    m_out = rdop ? {15'h0, rd} : c;
    m_ok = nb == 24 && !(act && op == OP_SRST);
    n.st = {m_slp, m_b[1], m_b[0], m_w[1], m_w[0]};
    notes.push_back(n);
    dwd_host_model_i.frame(c, nb);
  endtask
  always @(posedge mclk) begin
    if (done === 1'b1 && notes.size() > 0) begin
      dwd_note_type n;
      n = notes.pop_front();
      if (n.chk) check("sdo word", n.word, rx);
      if (n.bsy[1]) check("busy", 24'(n.bsy[0]), 24'(busy_seen));
      check("state", 24'(n.st), 24'(seen));
      check("sdo enable", 24'h2, 24'({oe_hi, sdo_oe}));
    end
  end
  // sdo enable as seen while the link clock is high inside a frame
  always @(posedge mclk) begin
    if (link_clk === 1'b1) oe_hi <= sdo_oe;
  end
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (80000) @(posedge mclk);
    err_count++;
    conclude();
  end
  initial begin
    logic [3:0] op;
    sys_rst = 1'b1;
    wp_n = 1'b1;
    err_count = 0;
    n_tests = 0;
    seed = 61;
    m_ok = 1'b0;
    m_out = 24'h0;
    for (int k = 0; k < 8; k++) m_s[k[0]][k[2:1]] = SLOT_INIT;
    power_up();
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (seq[i]) begin
      @(posedge mclk);
      wp_n <= !seq[i][25];
      @(posedge mclk);
      send(seq[i][23:0], seq[i][24] ? 23 : 24);
    end
    for (int i = 0; i < 30; i++) begin
      seed = xorshift(seed);
      op = ops[seed[10:8] % 5];
      send({op, 2'b00, seed[0] & (op != OP_RDWIPER), seed[1], seed[31:16]});
    end
    conclude();
  end
endmodule
